/* File: include/irq_enable_defines.svh */
// Purpose: Constants for the peripheral interrupt enable bank.
// Assumes: 32-bit classic Wishbone, one word per register.
// Notes: Offsets are byte addresses.
//
// Notes on behaviour
// RULE_01: Misc enable bits 7, 5, 4 read zero.
// RULE_02: Misc bit 6 gates comparator request.
// RULE_03: Misc bit 3 gates bus collision request.
// RULE_04: Misc bit 2 gates low-voltage detect request.
// RULE_05: Misc bit 1 gates timer three overflow.
// RULE_06: Misc bit 0 gates capture/compare two.
// RULE_07: CAN bit 7 gates invalid message request.
// RULE_08: CAN bit 6 gates bus wake request.
// RULE_09: CAN bit 5 gates bus error request.
// RULE_10: CAN bits 4..2 gate transmit buffers 2..0.
// RULE_11: CAN bits 1..0 gate receive buffers 1..0.
// RULE_12: Receive buffer zero flag set on new message.
// RULE_13: Request equals flag AND enable; flag untouched.
`ifndef IRQ_ENABLE_DEFINES_SVH
`define IRQ_ENABLE_DEFINES_SVH

// Register byte offsets
`define OFS_MISC_EN 8'h00
`define OFS_CAN_EN 8'h04
`define OFS_STATUS 8'h08
`define OFS_MASK 8'h0C

// Reset values
`define RST_MISC_EN 8'h00
`define RST_CAN_EN 8'hFF
`define RST_STATUS 16'h0000
`define RST_MASK 16'h0000

// Implemented bits of the misc enable register
`define MISC_IMPL_MASK 8'h4F

// Field positions, misc enable register
`define BIT_CMP 6
`define BIT_BCOL 3
`define BIT_LVD 2
`define BIT_TMR3 1
`define BIT_CCP2 0

// Field positions, CAN enable register
`define BIT_INVMSG 7
`define BIT_WAKE 6
`define BIT_CANERR 5
`define BIT_TXB2 4
`define BIT_TXB1 3
`define BIT_TXB0 2
`define BIT_RXB1 1
`define BIT_RXB0 0

// Status and mask layout: CAN group sits above the misc group
`define STAT_CAN_LSB 8

`endif

/* File: include/irq_enable_pkg.sv */
// Purpose: Types for the peripheral interrupt enable bank.
// Assumes: Constants come from irq_enable_defines.svh.
// Notes: Register select is decoded once and shared.
package irq_enable_pkg;
	typedef logic [7:0] en_byte_t;
	typedef logic [15:0] stat_word_t;
	typedef enum logic [2:0] {
		SEL_NONE = 3'h0,
		SEL_MISC_EN = 3'h1,
		SEL_CAN_EN = 3'h3,
		SEL_STATUS = 3'h2,
		SEL_MASK = 3'h6
	} reg_sel_t;
endpackage : irq_enable_pkg

/* File: rtl/peripheral_interrupt_enable_bank.sv */
// Purpose: Enable gating of misc and CAN interrupt sources, Wishbone slave.
// Assumes: Event inputs are one-cycle pulses synchronous to clk_i.
// Notes: Status is sticky and cleared by reading it; ack after one cycle.
//
// Implementation choices: the Wishbone register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "irq_enable_defines.svh"

module peripheral_interrupt_enable_bank
	import irq_enable_pkg::*;
#(
	parameter int ADDR_W = 8,
	parameter int DATA_W = 32
) (
	input wire logic clk_i, // System clock, 100 MHz
	input wire logic rst_i, // Synchronous reset, active high
	input wire logic cyc_i, // Wishbone cycle
	input wire logic stb_i, // Wishbone strobe
	input wire logic we_i, // Write enable
	input wire logic [ADDR_W-1:0] adr_i, // Byte address
	input wire logic [3:0] sel_i, // Byte lane selects
	input wire logic [DATA_W-1:0] dat_i, // Write data
	output logic [DATA_W-1:0] dat_o, // Read data
	output logic ack_o, // Acknowledge
	input wire logic [7:0] misc_event_i, // Misc source event pulses
	input wire logic [7:0] can_event_i, // CAN source event pulses
	output logic [7:0] misc_irq_req_o, // Gated misc requests
	output logic [7:0] can_irq_req_o, // Gated CAN requests
	output logic rx_buffer_zero_event_flag_o, // Receive buffer zero flag
	output logic irq_o // Combined interrupt, level
);

	////////////////////////////////////////////////////////////////////////
	// Elaboration checks
	if (DATA_W != 32) begin : g_bad_data
		$error("DATA_W must be 32");
	end
	if (ADDR_W < 4) begin : g_bad_addr
		$error("ADDR_W must be at least 4");
	end

	////////////////////////////////////////////////////////////////////////
	// State
	en_byte_t misc_irq_enable_ff;
	en_byte_t can_irq_enable_ff;
	stat_word_t status_ff;
	stat_word_t mask_ff;
	logic ack_ff;
	logic [DATA_W-1:0] dat_ff;
	logic [7:0] misc_req_ff;
	logic [7:0] can_req_ff;
	logic irq_ff;

	////////////////////////////////////////////////////////////////////////
	// Bus decode
	wire logic bus_req = cyc_i && stb_i && !ack_ff;
	wire logic [7:0] adr_byte = 8'(adr_i);
	wire logic adr_hi_zero = (ADDR_W > 8) ? ((adr_i >> 8) == '0) : 1'b1;
	wire reg_sel_t reg_sel =
		!adr_hi_zero ? SEL_NONE :
		(adr_byte == `OFS_MISC_EN) ? SEL_MISC_EN :
		(adr_byte == `OFS_CAN_EN) ? SEL_CAN_EN :
		(adr_byte == `OFS_STATUS) ? SEL_STATUS :
		(adr_byte == `OFS_MASK) ? SEL_MASK : SEL_NONE;
	wire logic wr_take = bus_req && we_i;
	wire logic rd_take = bus_req && !we_i;
	wire logic wr_misc = wr_take && (reg_sel == SEL_MISC_EN) && sel_i[0];
	wire logic wr_can = wr_take && (reg_sel == SEL_CAN_EN) && sel_i[0];
	wire logic wr_mask_lo = wr_take && (reg_sel == SEL_MASK) && sel_i[0];
	wire logic wr_mask_hi = wr_take && (reg_sel == SEL_MASK) && sel_i[1];
	wire logic rd_status = rd_take && (reg_sel == SEL_STATUS);

	////////////////////////////////////////////////////////////////////////
	// Next values for enables; unimplemented bits never store a one
	wire en_byte_t nxt_misc_irq_enable =
		wr_misc ? (dat_i[7:0] & `MISC_IMPL_MASK) : misc_irq_enable_ff; // RULE_01
	wire en_byte_t nxt_can_irq_enable =
		wr_can ? dat_i[7:0] : can_irq_enable_ff;
	wire stat_word_t nxt_mask = {
		wr_mask_hi ? dat_i[15:8] : mask_ff[15:8],
		wr_mask_lo ? (dat_i[7:0] & `MISC_IMPL_MASK) : mask_ff[7:0]
	};

	////////////////////////////////////////////////////////////////////////
	// Sticky event status; a new event wins over the read clear.
	// Enable writes never touch these flags.
	wire stat_word_t status_set = {can_event_i,
		misc_event_i & `MISC_IMPL_MASK}; // RULE_12
	wire stat_word_t status_clr = rd_status ? status_ff : '0;
	wire stat_word_t nxt_status =
		(status_ff & ~status_clr) | status_set; // RULE_13

	////////////////////////////////////////////////////////////////////////
	// Request gating: a source asks only while flag and enable are one
	wire en_byte_t misc_flags = status_ff[7:0];
	wire en_byte_t can_flags = status_ff[15:`STAT_CAN_LSB];
	// Spelled out per source so each gate can be traced to its enable
	wire en_byte_t nxt_misc_req = {
		1'b0, // RULE_01
		misc_flags[`BIT_CMP] & misc_irq_enable_ff[`BIT_CMP], // RULE_02
		2'b00, // RULE_01
		misc_flags[`BIT_BCOL] & misc_irq_enable_ff[`BIT_BCOL], // RULE_03
		misc_flags[`BIT_LVD] & misc_irq_enable_ff[`BIT_LVD], // RULE_04
		misc_flags[`BIT_TMR3] & misc_irq_enable_ff[`BIT_TMR3], // RULE_05
		misc_flags[`BIT_CCP2] & misc_irq_enable_ff[`BIT_CCP2] // RULE_06
	};
	wire en_byte_t nxt_can_req = {
		can_flags[`BIT_INVMSG] & can_irq_enable_ff[`BIT_INVMSG], // RULE_07
		can_flags[`BIT_WAKE] & can_irq_enable_ff[`BIT_WAKE], // RULE_08
		can_flags[`BIT_CANERR] & can_irq_enable_ff[`BIT_CANERR], // RULE_09
		can_flags[`BIT_TXB2:`BIT_TXB0] &
			can_irq_enable_ff[`BIT_TXB2:`BIT_TXB0], // RULE_10
		can_flags[`BIT_RXB1:`BIT_RXB0] &
			can_irq_enable_ff[`BIT_RXB1:`BIT_RXB0] // RULE_11
	};
	// Combined line also honours the mask, so software can silence a
	// source toward this output without losing its request line
	wire logic nxt_irq = |({nxt_can_req, nxt_misc_req} & mask_ff);

	////////////////////////////////////////////////////////////////////////
	// Read mux; unmapped offsets answer with zero rather than stall
	wire logic [DATA_W-1:0] nxt_dat =
		(reg_sel == SEL_MISC_EN) ? DATA_W'(misc_irq_enable_ff) :
		(reg_sel == SEL_CAN_EN) ? DATA_W'(can_irq_enable_ff) :
		(reg_sel == SEL_STATUS) ? DATA_W'(status_ff) :
		(reg_sel == SEL_MASK) ? DATA_W'(mask_ff) : '0;

	////////////////////////////////////////////////////////////////////////
	// Register update
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			misc_irq_enable_ff <= `RST_MISC_EN;
			can_irq_enable_ff <= `RST_CAN_EN;
			status_ff <= `RST_STATUS;
			mask_ff <= `RST_MASK;
		end else begin
			misc_irq_enable_ff <= nxt_misc_irq_enable;
			can_irq_enable_ff <= nxt_can_irq_enable;
			status_ff <= nxt_status;
			mask_ff <= nxt_mask;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Bus answer, one cycle after the request is seen
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_ff <= 1'b0;
			dat_ff <= '0;
		end else begin
			ack_ff <= bus_req;
			dat_ff <= rd_take ? nxt_dat : '0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Registered requests keep every output straight from a flop
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			misc_req_ff <= 8'h00;
			can_req_ff <= 8'h00;
			irq_ff <= 1'b0;
		end else begin
			misc_req_ff <= nxt_misc_req; // RULE_03
			can_req_ff <= nxt_can_req; // RULE_10
			irq_ff <= nxt_irq;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs
	assign dat_o = dat_ff;
	assign ack_o = ack_ff;
	assign misc_irq_req_o = misc_req_ff; // RULE_04
	assign can_irq_req_o = can_req_ff; // RULE_11
	assign rx_buffer_zero_event_flag_o = status_ff[`STAT_CAN_LSB + `BIT_RXB0];
	assign irq_o = irq_ff;

	////////////////////////////////////////////////////////////////////////
	// Assertions
	property p_misc_unimpl;
		@(posedge clk_i) disable iff (rst_i)
		(rd_take && reg_sel == SEL_MISC_EN) |=>
			(ack_o && dat_o[7] == 1'b0 && dat_o[5:4] == 2'b00);
	endproperty
	a_misc_unimpl: assert property (p_misc_unimpl) // RULE_01
		else $error("misc enable unimplemented bit read nonzero");

	property p_cmp_gate;
		@(posedge clk_i) disable iff (rst_i)
		misc_irq_req_o[`BIT_CMP] == ($past(misc_flags[`BIT_CMP])
			&& $past(misc_irq_enable_ff[`BIT_CMP]));
	endproperty
	a_cmp_gate: assert property (p_cmp_gate) // RULE_02
		else $error("comparator request not flag and enable");

	property p_bcol_gate;
		@(posedge clk_i) disable iff (rst_i)
		(!misc_irq_enable_ff[`BIT_BCOL]) |=> !misc_irq_req_o[`BIT_BCOL];
	endproperty
	a_bcol_gate: assert property (p_bcol_gate) // RULE_03
		else $error("bus collision request while disabled");

	property p_lvd_gate;
		@(posedge clk_i) disable iff (rst_i)
		(misc_event_i[`BIT_LVD] && misc_irq_enable_ff[`BIT_LVD]
			&& !wr_misc) |=> ##1 misc_irq_req_o[`BIT_LVD];
	endproperty
	a_lvd_gate: assert property (p_lvd_gate) // RULE_04
		else $error("low-voltage request missing two cycles after event");

	property p_tmr3_gate;
		@(posedge clk_i) disable iff (rst_i)
		(!misc_irq_enable_ff[`BIT_TMR3]) |=> !misc_irq_req_o[`BIT_TMR3];
	endproperty
	a_tmr3_gate: assert property (p_tmr3_gate) // RULE_05
		else $error("timer three request while disabled");

	property p_ccp2_gate;
		@(posedge clk_i) disable iff (rst_i)
		misc_irq_req_o[`BIT_CCP2] == ($past(misc_flags[`BIT_CCP2])
			&& $past(misc_irq_enable_ff[`BIT_CCP2]));
	endproperty
	a_ccp2_gate: assert property (p_ccp2_gate) // RULE_06
		else $error("capture/compare two request wrong");

	property p_invmsg_gate;
		@(posedge clk_i) disable iff (rst_i)
		can_irq_req_o[`BIT_INVMSG] == ($past(can_flags[`BIT_INVMSG])
			&& $past(can_irq_enable_ff[`BIT_INVMSG]));
	endproperty
	a_invmsg_gate: assert property (p_invmsg_gate) // RULE_07
		else $error("invalid message request wrong");

	property p_wake_gate;
		@(posedge clk_i) disable iff (rst_i)
		(!can_irq_enable_ff[`BIT_WAKE]) |=> !can_irq_req_o[`BIT_WAKE];
	endproperty
	a_wake_gate: assert property (p_wake_gate) // RULE_08
		else $error("bus wake request while disabled");

	property p_canerr_gate;
		@(posedge clk_i) disable iff (rst_i)
		can_irq_req_o[`BIT_CANERR] == ($past(can_flags[`BIT_CANERR])
			&& $past(can_irq_enable_ff[`BIT_CANERR]));
	endproperty
	a_canerr_gate: assert property (p_canerr_gate) // RULE_09
		else $error("bus error request wrong");

	property p_tx_gate;
		@(posedge clk_i) disable iff (rst_i)
		can_irq_req_o[4:2] ==
			($past(can_flags[4:2]) & $past(can_irq_enable_ff[4:2]));
	endproperty
	a_tx_gate: assert property (p_tx_gate) // RULE_10
		else $error("transmit buffer request wrong");

	property p_rx_gate;
		@(posedge clk_i) disable iff (rst_i)
		can_irq_req_o[1:0] ==
			($past(can_flags[1:0]) & $past(can_irq_enable_ff[1:0]));
	endproperty
	a_rx_gate: assert property (p_rx_gate) // RULE_11
		else $error("receive buffer request wrong");

	property p_rxb0_flag;
		@(posedge clk_i) disable iff (rst_i)
		can_event_i[`BIT_RXB0] |=> rx_buffer_zero_event_flag_o;
	endproperty
	a_rxb0_flag: assert property (p_rxb0_flag) // RULE_12
		else $error("receive buffer zero flag not set by event");

	property p_flag_untouched;
		@(posedge clk_i) disable iff (rst_i)
		((wr_misc || wr_can) && status_set == '0 && !rd_status) |=>
			$stable(status_ff);
	endproperty
	a_flag_untouched: assert property (p_flag_untouched) // RULE_13
		else $error("enable write altered event flags");

	property p_irq_level;
		@(posedge clk_i) disable iff (rst_i)
		irq_o == |({$past(can_flags) & $past(can_irq_enable_ff),
			$past(misc_flags) & $past(misc_irq_enable_ff)} & $past(mask_ff));
	endproperty
	a_irq_level: assert property (p_irq_level) // RULE_13
		else $error("interrupt output mismatch");

	property p_rd_clears;
		@(posedge clk_i) disable iff (rst_i)
		(rd_status && status_set == '0) |=> (status_ff == '0);
	endproperty
	a_rd_clears: assert property (p_rd_clears) // RULE_12
		else $error("status read did not clear the flags");

	property p_misc_write;
		@(posedge clk_i) disable iff (rst_i)
		wr_misc |=>
			(misc_irq_enable_ff == ($past(dat_i[7:0]) & `MISC_IMPL_MASK));
	endproperty
	a_misc_write: assert property (p_misc_write) // RULE_01
		else $error("misc enable write stored wrong value");

	property p_can_write;
		@(posedge clk_i) disable iff (rst_i)
		wr_can |=> (can_irq_enable_ff == $past(dat_i[7:0]));
	endproperty
	a_can_write: assert property (p_can_write) // RULE_07
		else $error("CAN enable write stored wrong value");

	// Absent sources must never leave a flag behind
	property p_misc_flags_zero;
		@(posedge clk_i) disable iff (rst_i)
		(status_ff[7] == 1'b0) && (status_ff[5:4] == 2'b00);
	endproperty
	a_misc_flags_zero: assert property (p_misc_flags_zero) // RULE_01
		else $error("unimplemented misc flag set");

endmodule : peripheral_interrupt_enable_bank
`default_nettype wire

/* File: verification/event_source_model.sv */
// Purpose: Peripheral flag sources that feed the enable bank.
// Assumes: Fire requests are driven just after a rising edge.
// Notes: Each request becomes one registered event pulse.
`timescale 1ns/10ps
`default_nettype none

module event_source_model (
	input wire logic clk_i, // System clock
	input wire logic rst_i, // Synchronous reset
	input wire logic [7:0] misc_fire_i, // Misc events to raise
	input wire logic [7:0] can_fire_i, // CAN events to raise
	output logic [7:0] misc_event_o, // Misc event pulses
	output logic [7:0] can_event_o // CAN event pulses
);
	////////////////////////////////////////////////////////////////////////
	// Registered so a pulse never changes in the edge that samples it
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			misc_event_o <= 8'h00;
			can_event_o <= 8'h00;
		end else begin
			misc_event_o <= misc_fire_i;
			can_event_o <= can_fire_i;
		end
	end
endmodule : event_source_model
`default_nettype wire

/* File: verification/peripheral_interrupt_enable_bank_test.sv */
// Purpose: Self-checking bench for the interrupt enable bank.
// Assumes: Status reads clear flags; mask gates only the summary line.
// Notes: Table rows cover gating; awkward cases follow by hand.
`timescale 1ns/10ps
`default_nettype none

module peripheral_interrupt_enable_bank_test;
	typedef struct packed {
		logic [7:0] me, ce, mv, cv, mr, cr;
	} row_t;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'hF;
	logic [31:0] wdat = 32'h0;
	logic [31:0] q, dat_o;
	logic ack_o, irq_o, rx_flag;
	logic [7:0] mf = 8'h00;
	logic [7:0] cf = 8'h00;
	logic [7:0] mev, cev, mreq, creq;
	int err_count = 0;
	int n_compared = 0;
	// Enables, events, then the requests they should give
	row_t rows [4] = '{
		'{8'hFF, 8'h00, 8'hFF, 8'hFF, 8'h4F, 8'h00},
		'{8'h00, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'hFF},
		'{8'h4A, 8'hA5, 8'h0F, 8'h3C, 8'h0A, 8'h24},
		'{8'h45, 8'h5A, 8'h45, 8'hFF, 8'h45, 8'h5A}};

	always #5 clk_i = ~clk_i;

	peripheral_interrupt_enable_bank #(.ADDR_W(8), .DATA_W(32))
		peripheral_interrupt_enable_bank_i (.clk_i(clk_i), .rst_i(rst_i),
		.cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
		.dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o), .misc_event_i(mev),
		.can_event_i(cev), .misc_irq_req_o(mreq), .can_irq_req_o(creq),
		.rx_buffer_zero_event_flag_o(rx_flag), .irq_o(irq_o));
	event_source_model event_source_model_i (.clk_i(clk_i), .rst_i(rst_i),
		.misc_fire_i(mf), .can_fire_i(cf), .misc_event_o(mev),
		.can_event_o(cev));

	////////////////////////////////////////////////////////////////////////
	// Verdict and counts, also the exit for an expired wait
	task automatic stop_test();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : stop_test

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
			err_count++;
		end
	endtask : cmp

	// One classic cycle; the leading edge keeps strobe low between cycles
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d, input logic [3:0] s, output logic [31:0] r);
		int n;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= s;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 20);
		r = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		if (n >= 20) begin
			err_count++;
			stop_test();
		end
	endtask : wb

	// Fire events, then wait out the two-cycle request latency
	task automatic fire(input logic [7:0] m, input logic [7:0] c);
		@(posedge clk_i);
		mf <= m;
		cf <= c;
		@(posedge clk_i);
		mf <= 8'h00;
		cf <= 8'h00;
		repeat (3) @(posedge clk_i);
		@(negedge clk_i);
	endtask : fire

	// Reset values of the registers and the quiet outputs
	task automatic chk_reset();
		logic [31:0] r;
		cmp({24'h0, mreq}, 32'h0);
		cmp({24'h0, creq}, 32'h0);
		cmp({31'h0, rx_flag}, 32'h0);
		wb(1'b0, 8'h00, 32'h0, 4'hF, r);
		cmp(r, 32'h00);
		wb(1'b0, 8'h04, 32'h0, 4'hF, r);
		cmp(r, 32'hFF);
		wb(1'b0, 8'h08, 32'h0, 4'hF, r);
		cmp(r, 32'h00);
		wb(1'b0, 8'h0C, 32'h0, 4'hF, r);
		cmp(r, 32'h00);
	endtask : chk_reset

	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		@(negedge clk_i);
		chk_reset();
		$display("test reset done");
		foreach (rows[i]) begin
			wb(1'b1, 8'h00, {24'h0, rows[i].me}, 4'hF, q);
			wb(1'b1, 8'h04, {24'h0, rows[i].ce}, 4'hF, q);
			wb(1'b0, 8'h00, 32'h0, 4'hF, q);
			cmp(q, {24'h0, rows[i].me & 8'h4F});
			fire(rows[i].mv, rows[i].cv);
			cmp({24'h0, mreq}, {24'h0, rows[i].mr});
			cmp({31'h0, mreq[6]}, {31'h0, rows[i].mr[6]});
			cmp({31'h0, mreq[3]}, {31'h0, rows[i].mr[3]});
			cmp({31'h0, mreq[2]}, {31'h0, rows[i].mr[2]});
			cmp({31'h0, mreq[1]}, {31'h0, rows[i].mr[1]});
			cmp({31'h0, mreq[0]}, {31'h0, rows[i].mr[0]});
			cmp({31'h0, creq[7]}, {31'h0, rows[i].cr[7]});
			cmp({31'h0, creq[6]}, {31'h0, rows[i].cr[6]});
			cmp({31'h0, creq[5]}, {31'h0, rows[i].cr[5]});
			cmp({29'h0, creq[4:2]}, {29'h0, rows[i].cr[4:2]});
			cmp({30'h0, creq[1:0]}, {30'h0, rows[i].cr[1:0]});
			cmp({31'h0, rx_flag}, {31'h0, rows[i].cv[0]});
			wb(1'b0, 8'h08, 32'h0, 4'hF, q);
			cmp(q, {16'h0, rows[i].cv, rows[i].mv & 8'h4F});
			wb(1'b0, 8'h08, 32'h0, 4'hF, q);
			cmp(q, 32'h0);
			$display("test row %0d done", i);
		end
		// Summary line follows the mask; a status read drops it
		wb(1'b1, 8'h04, 32'hFF, 4'hF, q);
		wb(1'b1, 8'h0C, 32'h100, 4'hF, q);
		fire(8'h00, 8'h01);
		cmp({31'h0, irq_o}, 32'h1);
		wb(1'b0, 8'h08, 32'h0, 4'hF, q);
		cmp(q, 32'h100);
		repeat (2) @(posedge clk_i);
		@(negedge clk_i);
		cmp({31'h0, irq_o}, 32'h0);
		cmp({24'h0, creq}, 32'h0);
		wb(1'b1, 8'h0C, 32'h0, 4'hF, q);
		fire(8'h00, 8'h01);
		cmp({31'h0, irq_o}, 32'h0);
		cmp({24'h0, creq}, 32'h1);
		wb(1'b0, 8'h08, 32'h0, 4'hF, q);
		cmp(q, 32'h100);
		$display("test interrupt done");
		// Lane zero off leaves the byte; unmapped space reads zero
		wb(1'b1, 8'h00, 32'h4F, 4'hE, q);
		wb(1'b0, 8'h00, 32'h0, 4'hF, q);
		cmp(q, 32'h45);
		wb(1'b1, 8'h10, 32'hFF, 4'hF, q);
		wb(1'b0, 8'h10, 32'h0, 4'hF, q);
		cmp(q, 32'h0);
		wb(1'b1, 8'h0C, 32'hFFFF, 4'hF, q);
		wb(1'b0, 8'h0C, 32'h0, 4'hF, q);
		cmp(q, 32'hFF4F);
		$display("test lanes done");
		// Reset in mid-run drops flags, requests and the summary line
		fire(8'h4F, 8'hFF);
		cmp({31'h0, irq_o}, 32'h1);
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(negedge clk_i);
		cmp({31'h0, irq_o}, 32'h0);
		chk_reset();
		$display("test mid-run reset done");
		stop_test();
	end
endmodule : peripheral_interrupt_enable_bank_test
`default_nettype wire
